// ===== multiturn_position_output.sv
/*
 * Multi-turn position output: builds the 24-bit position word from the raw
 * shaft count, applies count sense, zero offset and code, and presents it on
 * a parallel bus (hold, output enable) and on a synchronous serial link.
 * Assumes the non-volatile offset store lives outside; the block exports the
 * offset and a save strobe, and software reloads it over AXI4-Lite at power-up.
 */
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
module multiturn_position_output
  import mtpos_pkg::*;
#(
  parameter longint ZERO_HOLD_CYC = ZERO_HOLD_CYC_DEF
) (
  // System clock and reset
  input  wire logic              CLK_SYS,
  input  wire logic              RST_N,
  // Raw shaft count from the sensing front end, clockwise increasing
  input  wire logic [POS_W-1:0]  SHAFT_COUNT,
  // Control pins, pulled up externally so undriven reads high
  input  wire logic              COUNT_SENSE_INPUT,
  input  wire logic              HOLD_N,
  input  wire logic              OUT_ENABLE,
  input  wire logic              ZERO_SET_N,
  // Parallel position outputs, three-state by enable
  output logic [TURN_W-1:0]      TURN_COUNT_BITS,
  output logic [FINE_W-1:0]      FINE_COUNT_BITS,
  output logic                   POS_OE,
  // Serial link, clocked by the controller
  input  wire logic              SER_CLK,
  input  wire logic              SER_RST_N,
  output logic                   SER_DATA,
  output logic                   SER_DATA_OE,
  // Non-volatile offset store interface
  output logic [POS_W-1:0]       NV_OFFSET,
  output logic                   NV_SAVE,
  // AXI4-Lite slave
  input  wire logic [7:0]        S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [7:0]        S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Binary to reflected gray
  function automatic logic [POS_W-1:0] to_gray(input logic [POS_W-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  // Merge a 32-bit write into a register under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers (two flops, first read only by second)

  logic [3:0]       pin_s1;           // First stage, control pins
  logic [3:0]       pin_s2;           // Second stage, usable
  logic [POS_W-1:0] shaft_s1;         // First stage, shaft count
  logic [POS_W-1:0] shaft_s2;         // Second stage

  // Reset to the pulled-up level so an undriven pin reads high
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pin_s1 <= 4'hF;
      pin_s2 <= 4'hF;
      shaft_s1 <= '0;
      shaft_s2 <= '0;
    end else begin
      pin_s1 <= {ZERO_SET_N, OUT_ENABLE, HOLD_N, COUNT_SENSE_INPUT};
      pin_s2 <= pin_s1;
      shaft_s1 <= SHAFT_COUNT;
      shaft_s2 <= shaft_s1;
    end
  end

  wire sense_hi = pin_s2[0];          // Count sense level
  wire live     = pin_s2[1];          // Hold pin high means live
  wire oe_pin   = pin_s2[2];          // Enable pin level
  wire zero_lo  = ~pin_s2[3];         // Zero-set being asserted

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [2:0]       ctrl;             // Gray, ccw-variant, enable-option
  logic [POS_W-1:0] offset;           // Zero offset in directed counts

  wire gray_mode = ctrl[CTRL_GRAY_BIT];
  wire ccw_var   = ctrl[CTRL_CCWV_BIT];
  wire oe_opt    = ctrl[CTRL_OEOPT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Position path

  // Clockwise-up when sense high, reversed when low; variant swaps meaning
  wire               cw_up    = sense_hi ^ ccw_var;
  wire [POS_W-1:0]   directed = cw_up ? shaft_s2 : POS_W'(-shaft_s2);
  wire [POS_W-1:0]   rel_pos  = POS_W'(directed - offset);
  wire [POS_W-1:0]   coded    = gray_mode ? to_gray(rel_pos) : rel_pos;

  logic [POS_W-1:0]  word;            // Current coded word, turn bits high

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      word <= '0;
    end else begin
      word <= coded;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero-set timer

  logic [31:0] zero_cnt;              // Cycles the zero-set pin has stayed low
  logic        zero_done;             // One save per assertion
  wire         zero_fire = zero_lo && !zero_done && (zero_cnt == 32'(ZERO_HOLD_CYC - 1));

  // Count a continuous low; release restarts the count
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      zero_cnt <= '0;
      zero_done <= 1'b0;
    end else if (!zero_lo) begin
      zero_cnt <= '0;
      zero_done <= 1'b0;
    end else if (zero_fire) begin
      zero_done <= 1'b1;
    end else if (!zero_done) begin
      zero_cnt <= zero_cnt + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parallel outputs

  logic [POS_W-1:0] par_word;         // Word on the parallel pins

  // Follow the word while live, freeze while held
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      par_word <= '0;
      POS_OE <= 1'b0;
    end else begin
      if (live) begin
        par_word <= word;
      end
      POS_OE <= oe_pin || !oe_opt;
    end
  end

  assign TURN_COUNT_BITS = par_word[POS_W-1 -: TURN_W];
  assign FINE_COUNT_BITS = par_word[FINE_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Word crossing into the serial domain (toggle handshake)

  logic [POS_W-1:0] xfer_word;        // Held stable while the toggle crosses
  logic             xfer_tog;         // Flips on each new word
  logic [2:0]       ack_sync;         // Serial ack toggle back into system domain

  wire              ack_eq = (ack_sync[2] == xfer_tog);

  // Load a fresh word only once the previous one was taken
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      xfer_word <= '0;
      xfer_tog <= 1'b0;
      ack_sync <= '0;
    end else begin
      ack_sync <= {ack_sync[1:0], ser_ack};
      if (ack_eq) begin
        xfer_word <= word;
        xfer_tog <= ~xfer_tog;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial domain

  logic [1:0]       tog_sync;         // Request toggle in serial domain
  logic             ser_ack;          // Echo of the request toggle
  logic [POS_W-1:0] ser_copy;         // Latest word seen in serial domain
  logic [SER_W-1:0] shreg;            // Shift register
  logic [4:0]       bitn;             // Bits left in the burst
  ser_state_type    ser_state;        // Idle or shifting

  // Copy the word when a new toggle arrives and echo it on the same clock
  always_ff @(posedge SER_CLK or negedge SER_RST_N) begin
    if (!SER_RST_N) begin
      tog_sync <= '0;
      ser_ack <= 1'b0;
      ser_copy <= '0;
    end else begin
      tog_sync <= {tog_sync[0], xfer_tog};
      if (tog_sync[1] != ser_ack) begin
        ser_copy <= xfer_word;
        ser_ack <= tog_sync[1];
      end
    end
  end

  // First clock of a burst captures and drives the MSB, then one bit per clock MSB first
  always_ff @(posedge SER_CLK or negedge SER_RST_N) begin
    if (!SER_RST_N) begin
      ser_state <= SER_IDLE;
      shreg <= '0;
      bitn <= '0;
      SER_DATA <= 1'b0;
    end else begin
      unique case (ser_state)
        SER_IDLE: begin
          shreg <= {ser_copy[SER_W-2:0], 1'b0};
          SER_DATA <= ser_copy[SER_W-1];
          bitn <= 5'(SER_W - 1);
          ser_state <= SER_SHIFT;
        end
        SER_SHIFT: begin
          SER_DATA <= shreg[SER_W-1];
          shreg <= {shreg[SER_W-2:0], 1'b0};
          bitn <= bitn - 5'h01;
          if (bitn == 5'h01) begin
            ser_state <= SER_IDLE;
          end
        end
      endcase
    end
  end

  // Serial line follows the same enable as the parallel pins
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      SER_DATA_OE <= 1'b0;
    end else begin
      SER_DATA_OE <= oe_pin || !oe_opt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset register and save strobe

  logic aw_hold;                      // Write address taken
  logic w_hold;                       // Write data taken
  logic [7:0]  aw_addr;               // Latched write address
  logic [31:0] w_data;                // Latched write data
  logic [3:0]  w_strb;                // Latched strobes
  wire         do_write = aw_hold && w_hold && !S_AXI_BVALID;
  wire         wr_ctrl  = do_write && (aw_addr == CTRL_OFS);
  wire         wr_off   = do_write && (aw_addr == OFFSET_OFS);
  wire         wr_ok    = (aw_addr == CTRL_OFS) || (aw_addr == OFFSET_OFS);

  // Zero-set replaces the offset and wins over a software write
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      offset <= OFFSET_RST;
      ctrl <= CTRL_RST;
      NV_SAVE <= 1'b0;
      NV_OFFSET <= OFFSET_RST;
    end else begin
      NV_SAVE <= zero_fire;
      if (zero_fire) begin
        offset <= directed;
      end else if (wr_off) begin
        offset <= POS_W'(merge({8'h00, offset}, w_data, w_strb));
      end
      if (wr_ctrl) begin
        ctrl <= 3'(merge({29'h0, ctrl}, w_data, w_strb));
      end
      NV_OFFSET <= offset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  // Take address and data in either order, answer after both
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !aw_hold && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY <= !w_hold && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  logic [31:0] rd_mux;                // Read data selection
  logic        rd_ok;                 // Address is mapped

  always_comb begin
    rd_ok = 1'b1;
    unique case (S_AXI_ARADDR)
      CTRL_OFS:   rd_mux = {29'h0, ctrl};
      SHAFT_OFS:  rd_mux = {8'h00, shaft_s2};
      OFFSET_OFS: rd_mux = {8'h00, offset};
      POS_OFS:    rd_mux = {8'h00, word};
      STAT_OFS:   rd_mux = {28'h0, pin_s2};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // One cycle to accept, data on the next
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_mux;
        S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule

// ===== mtpos_pkg.sv
/*
 * Package for the multi-turn position output block: field widths, register
 * offsets, reset values and timing constants.
 * Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package mtpos_pkg;

  // Position word layout
  localparam int TURN_W = 12;
  localparam int FINE_W = 12;
  localparam int POS_W  = 24;
  localparam int SER_W  = 24;

  // Clock rate and the zero-set least hold time
  localparam longint CLK_HZ       = 50_000_000;
  localparam longint ZERO_HOLD_MS = 1000;
  localparam longint ZERO_HOLD_CYC_DEF = (ZERO_HOLD_MS * CLK_HZ + 999) / 1000;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] SHAFT_OFS  = 8'h04;
  localparam logic [7:0] OFFSET_OFS = 8'h08;
  localparam logic [7:0] POS_OFS    = 8'h0C;
  localparam logic [7:0] STAT_OFS   = 8'h10;

  // Control register fields
  localparam int CTRL_GRAY_BIT  = 0;
  localparam int CTRL_CCWV_BIT  = 1;
  localparam int CTRL_OEOPT_BIT = 2;

  // Reset values
  localparam logic [2:0]  CTRL_RST   = 3'h4;
  localparam logic [23:0] OFFSET_RST = 24'h00_0000;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Serial shifter states
  typedef enum logic [0:0] {
    SER_IDLE  = 1'b0,
    SER_SHIFT = 1'b1
  } ser_state_type;

endpackage

// ===== multiturn_position_output_checker.sv
/*
 * Port-level assertions for the multi-turn position output block.
 * Assumes it is bound to the top module, and that the enable option bit
 * stays set while the enable pin is driven low.
 */
`timescale 1ns/100ps
module multiturn_position_output_checker
  import mtpos_pkg::*;
#(
  parameter longint ZERO_HOLD_CYC = 20
) (
  // Clock and reset
  input wire logic              CLK_SYS,
  input wire logic              RST_N,
  // Control pins
  input wire logic              HOLD_N,
  input wire logic              OUT_ENABLE,
  input wire logic              ZERO_SET_N,
  // Parallel outputs and offset store
  input wire logic [TURN_W-1:0] TURN_COUNT_BITS,
  input wire logic [FINE_W-1:0] FINE_COUNT_BITS,
  input wire logic              POS_OE,
  input wire logic              NV_SAVE,
  // Bus handshakes
  input wire logic              S_AXI_AWVALID,
  input wire logic              S_AXI_AWREADY,
  input wire logic              S_AXI_WVALID,
  input wire logic              S_AXI_WREADY,
  input wire logic              S_AXI_BVALID,
  input wire logic              S_AXI_ARVALID,
  input wire logic              S_AXI_ARREADY,
  input wire logic              S_AXI_RVALID,
  input wire logic [1:0]        S_AXI_RRESP
);
  ////////////////////////////////////////////////////////////////////////////
  // Consecutive low cycles of the zero-set pin, saturating so it never wraps
  logic [31:0] low_cnt;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      low_cnt <= 32'h0000_0000;
    end else begin
      low_cnt <= ZERO_SET_N ? 32'h0000_0000 : low_cnt + {31'h0, ~&low_cnt};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  // Pipeline lag is a few cycles, so the freeze is judged after six
  property p_hold_freeze;
    (!HOLD_N) [*6] |-> $stable({TURN_COUNT_BITS, FINE_COUNT_BITS});
  endproperty
  a_hold_freeze: assert property (p_hold_freeze)
    else $error("Parallel word moved while held");

  property p_oe_off;
    (!OUT_ENABLE) [*6] |-> !POS_OE;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("Outputs driven while enable low");

  property p_oe_on;
    OUT_ENABLE [*8] |-> POS_OE;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("Outputs floating while enable high");

  property p_save_len;
    NV_SAVE |-> low_cnt >= ZERO_HOLD_CYC;
  endproperty
  a_save_len: assert property (p_save_len)
    else $error("Offset saved after too short a request");

  property p_save_pulse;
    NV_SAVE |=> !NV_SAVE;
  endproperty
  a_save_pulse: assert property (p_save_pulse)
    else $error("Save strobe longer than one cycle");

  property p_zero_out;
    NV_SAVE && HOLD_N |-> ##[1:10] (TURN_COUNT_BITS == 12'h000 && FINE_COUNT_BITS == 12'h000);
  endproperty
  a_zero_out: assert property (p_zero_out)
    else $error("Position not zero after zero set");

  property p_write_resp;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:3] S_AXI_BVALID;
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("Write response late");

  property p_read_resp;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_read_resp: assert property (p_read_resp)
    else $error("Read data late");

  property p_ar_pulse;
    S_AXI_ARREADY |=> !S_AXI_ARREADY;
  endproperty
  a_ar_pulse: assert property (p_ar_pulse)
    else $error("Read address ready held too long");

  // Main scenarios reached
  c_save: cover property (NV_SAVE);
  c_freeze: cover property ((!HOLD_N) [*6]);
  c_slverr: cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);
endmodule

bind multiturn_position_output multiturn_position_output_checker
  #(.ZERO_HOLD_CYC(ZERO_HOLD_CYC)) u_checker (.*);

// ===== link_reader.sv
/*
 * Controller-side model of the serial link: on request it sends one burst of
 * clock pulses and assembles the word. Assumes the bench pulls the data line
 * high whenever the device does not drive it.
 */
`timescale 1ns/100ps
module link_reader
  import mtpos_pkg::*;
(
  // Burst request and completion
  input wire logic        go,
  output logic            done,
  // Link pins
  output logic            ser_clk,
  input wire logic        ser_data,
  // Assembled word
  output logic [SER_W-1:0] word
);
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    done = 1'b0;
    ser_clk = 1'b0;
    word = '0;
  end

  // The clock stands still low between bursts; 12 ns period inside one
  always begin
    @(posedge go);
    done = 1'b0;
    #3.7;
    for (int i = 0; i < SER_W; i++) begin
      #6 ser_clk = 1'b1;
      #6 ser_clk = 1'b0;
      word = {word[SER_W-2:0], ser_data};
    end
    #12 done = 1'b1;
  end
endmodule

// ===== tb_multiturn_position_output.sv
/*
 * Self-checking bench for the multi-turn position output block.
 * Assumes a shortened zero-set hold and software restore of the offset.
 */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_multiturn_position_output
  import mtpos_pkg::*;
;
  localparam longint ZHC = 20; // Short zero-set hold for simulation
  ////////////////////////////////////////////////////////////////////////////
  logic              CLK_SYS = 1'b0, RST_N = 1'b0, SER_RST_N = 1'b0;
  logic              COUNT_SENSE_INPUT = 1'b1, HOLD_N = 1'b1;
  logic              OUT_ENABLE = 1'b1, ZERO_SET_N = 1'b1;
  logic [POS_W-1:0]  SHAFT_COUNT = 24'h00_0000, NV_OFFSET;
  logic [TURN_W-1:0] TURN_COUNT_BITS;
  logic [FINE_W-1:0] FINE_COUNT_BITS;
  logic              POS_OE, SER_CLK, SER_DATA, SER_DATA_OE, NV_SAVE, sdat, go = 1'b0, done;
  logic [7:0]        S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0]       S_AXI_WDATA = 32'h0000_0000, S_AXI_RDATA;
  logic [3:0]        S_AXI_WSTRB = 4'hF;
  logic              S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic              S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic              S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0]        S_AXI_BRESP, S_AXI_RRESP;
  logic [SER_W-1:0]  ser_word;
  int                failures = 0, cmp_count = 0;

  always #10 CLK_SYS = ~CLK_SYS;
  // Pulled-up data line, so a released driver reads high
  assign sdat = SER_DATA_OE ? SER_DATA : 1'b1;

  multiturn_position_output #(.ZERO_HOLD_CYC(ZHC)) DUT (.*);
  link_reader u_reader (.go(go), .done(done), .ser_clk(SER_CLK), .ser_data(sdat), .word(ser_word));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [POS_W-1:0] exp_pos(input logic [POS_W-1:0] s, input logic [POS_W-1:0] o);
    return s - o;
  endfunction
  // Expected change of the word for one clockwise count
  function automatic logic [POS_W-1:0] step(input logic sense, input logic ccw);
    return (sense ^ ccw) ? 24'h00_0001 : 24'hFF_FFFF;
  endfunction

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic timeout;
    failures++;
    $display("[ERR] wait exp answer got none");
    test_done();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Bus master: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      n++;
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID && n < 64);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
    if (n >= 64) timeout();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      n++;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID && n < 64);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    if (n >= 64) timeout();
  endtask
  // Zero-set request held low for a given number of cycles
  task automatic zero_set(input int len, output logic seen);
    @(posedge CLK_SYS);
    ZERO_SET_N <= 1'b0;
    seen = 1'b0;
    repeat (len) begin
      @(posedge CLK_SYS);
      if (NV_SAVE === 1'b1) seen = 1'b1;
    end
    ZERO_SET_N <= 1'b1;
    tick(10);
  endtask
  task automatic burst(output logic [SER_W-1:0] w);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    go <= 1'b1;
    @(posedge CLK_SYS);
    go <= 1'b0;
    while (done !== 1'b1 && n < 100) begin
      @(posedge CLK_SYS);
      n++;
    end
    w = ser_word;
    if (n >= 100) timeout();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [POS_W-1:0] s, p0, o;
    logic [SER_W-1:0] w;
    logic [SER_W-1:0] prev;
    logic seen;
    void'($urandom(60));
    tick(10);
    RST_N <= 1'b1;
    SER_RST_N <= 1'b1;
    // Control register reset value and an unmapped address
    rd(CTRL_OFS, d, r);
    `CHK("ctrl", {29'h0, CTRL_RST}, d);
    rd(8'h14, d, r);
    `CHK("rresp", RESP_SLVERR, r);
    `CHK("rdata", 32'h0000_0000, d);
    wr(8'h14, 32'hFFFF_FFFF, r);
    `CHK("bresp", RESP_SLVERR, r);
    // Live word: extremes, then random
    for (int i = 0; i < 8; i++) begin
      s = (i == 0) ? 24'h00_0000 : (i == 1) ? 24'hFF_FFFF : 24'($urandom);
      SHAFT_COUNT <= s;
      tick(8);
      `CHK("turn", s[23:12], TURN_COUNT_BITS);
      `CHK("fine", s[11:0], FINE_COUNT_BITS);
      rd(POS_OFS, d, r);
      `CHK("posreg", s, d[23:0]);
    end
    // Count sense in both build variants
    for (int k = 0; k < 4; k++) begin
      wr(CTRL_OFS, {29'h0, 1'b1, k[1], 1'b0}, r);
      COUNT_SENSE_INPUT <= k[0];
      s = 24'($urandom);
      SHAFT_COUNT <= s;
      tick(8);
      p0 = {TURN_COUNT_BITS, FINE_COUNT_BITS};
      SHAFT_COUNT <= s + 24'h00_0001;
      tick(8);
      `CHK("step", step(k[0], k[1]), {TURN_COUNT_BITS, FINE_COUNT_BITS} - p0);
    end
    COUNT_SENSE_INPUT <= 1'b1;
    // Gray code: a step that flips twelve binary bits flips one
    wr(CTRL_OFS, 32'h0000_0005, r);
    s = {12'($urandom), 12'h7FF};
    SHAFT_COUNT <= s;
    tick(8);
    p0 = {TURN_COUNT_BITS, FINE_COUNT_BITS};
    SHAFT_COUNT <= s + 24'h00_0001;
    tick(8);
    `CHK("gray", 1, $countones(p0 ^ {TURN_COUNT_BITS, FINE_COUNT_BITS}));
    wr(CTRL_OFS, 32'h0000_0004, r);
    // Freeze while held, live again after
    s = 24'($urandom);
    SHAFT_COUNT <= s;
    tick(8);
    HOLD_N <= 1'b0;
    tick(2);
    SHAFT_COUNT <= ~s;
    tick(8);
    `CHK("held", s, {TURN_COUNT_BITS, FINE_COUNT_BITS});
    HOLD_N <= 1'b1;
    tick(8);
    `CHK("live", ~s, {TURN_COUNT_BITS, FINE_COUNT_BITS});
    OUT_ENABLE <= 1'b0;
    tick(8);
    `CHK("oe_off", 1'b0, POS_OE);
    OUT_ENABLE <= 1'b1;
    tick(8);
    `CHK("oe_on", 1'b1, POS_OE);
    // Zero set: too short is ignored, then two valid ones
    s = 24'($urandom);
    SHAFT_COUNT <= s;
    tick(8);
    zero_set(int'(ZHC / 2), seen);
    `CHK("short", 1'b0, seen);
    `CHK("nozero", s, {TURN_COUNT_BITS, FINE_COUNT_BITS});
    for (int j = 0; j < 2; j++) begin
      zero_set(int'(ZHC * 2), seen);
      `CHK("save", 1'b1, seen);
      `CHK("zero", 24'h00_0000, {TURN_COUNT_BITS, FINE_COUNT_BITS});
      `CHK("nvoff", s, NV_OFFSET);
      o = s;
      s = s + 24'h00_1234;
      SHAFT_COUNT <= s;
      tick(8);
      `CHK("moved", exp_pos(s, o), {TURN_COUNT_BITS, FINE_COUNT_BITS});
    end
    // Power cycle; software restores the saved offset
    RST_N <= 1'b0;
    SER_RST_N <= 1'b0;
    tick(3);
    RST_N <= 1'b1;
    SER_RST_N <= 1'b1;
    wr(OFFSET_OFS, {8'h00, o}, r);
    tick(8);
    `CHK("restored", exp_pos(s, o), {TURN_COUNT_BITS, FINE_COUNT_BITS});
    // Serial bursts, two back to back per position. The link clock stands
    // still between bursts, so the first burst still carries the word the
    // serial side captured during the last clocks it saw; the second is fresh.
    prev = '0;
    for (int i = 0; i < 4; i++) begin
      burst(w);
      `CHK("serial_first", prev, w);
      burst(w);
      `CHK("serial", exp_pos(s, o), w);
      prev = exp_pos(s, o);
      s = 24'($urandom);
      SHAFT_COUNT <= s;
      tick(12);
    end
    test_done();
  end
endmodule
